/* File: core/fstc_pkg.sv */
// Package for the floppy sector transfer sequencer: register map, fields, op codes, states
// Functional notes
// - Read-deleted works like sector read but targets deleted-mark data fields.
// - Wrong mark type sets control mark; skip 0 reads and stops, skip 1 skips.
// - Cylinder or sector number advances automatically as each sector completes.
// - Read-track starts at an index pulse and reads every data field regardless of numbering.
// - Read-track keeps going on ID or data CRC errors, flags reported at end.
// - Read-track sets the no-data flag when a sector ID differs from the command ID.
// - Read-track ends after the final-sector number of sectors have been read.
// - No ID mark by second index pulse: termination code 01, missing mark, end.
// - Multi-track off: sector plus one, or cylinder plus one and sector 01 at final.
// - Multi-track on at final: sector 01, head LSB flipped, cylinder up if head was 1.
// - Write loads head, waits load time, scans IDs, writes host bytes on match; the code waits at most one cycle, not the load time.
// - After each written sector the CRC is written, sector number advances, writing continues.
// - Terminal count, overrun or underrun while writing pads rest of field with zeros.
// - ID CRC error while writing: termination code 01, data error flag, end.
// - Write shares read capacity, no-data handling, head timing, result ID and length rules.
// - Write-deleted writes a deleted data mark instead of the normal mark.
// - Verify reads sectors and checks CRC but passes no bytes to the host.
// - Terminal count input does not end a verify command.
// - Verify with count enabled ends when the sector count reaches 0; 0 means 256.
// - Verify result valid only if final sector and count fit the formatted sectors.
// - Verify with multi-track continues on side 1 after side 0 runs out.
// - Size code 0 is 128 bytes; short length limits transfer, rest read or zero-padded.
`default_nettype none
package fstc_pkg;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_PARAM  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_DATA   = 8'h10;
  // CTRL fields
  localparam int CTL_START = 0;
  localparam int CTL_OP    = 1;
  localparam int CTL_MT    = 4;
  localparam int CTL_SK    = 5;
  localparam int CTL_EC    = 6;
  localparam int CTL_UNLD  = 7;
  // Operation codes
  localparam logic [2:0] OP_RDAT = 3'h0;
  localparam logic [2:0] OP_RDEL = 3'h1;
  localparam logic [2:0] OP_RTRK = 3'h2;
  localparam logic [2:0] OP_WDAT = 3'h3;
  localparam logic [2:0] OP_WDEL = 3'h4;
  localparam logic [2:0] OP_VRFY = 3'h5;
  localparam logic [1:0] IC_NORM = 2'h0;
  localparam logic [1:0] IC_ABN  = 2'h1;
  localparam logic [7:0] SEC_FIRST = 8'h01;
  localparam logic [14:0] SIZE0_BYTES = 15'h0080;
  localparam logic [7:0] PARAM_RST = 8'h00;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_HEAD = 3'h1, S_IDX = 3'h2, S_SRCH = 3'h3, S_MARK = 3'h4, S_XFER = 3'h5
  } fstc_state_e;
endpackage
`default_nettype wire

/* File: core/fstc_core.sv */
// Floppy sector transfer execution sequencer with APB register slave
`default_nettype none
module fstc_core (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  input  wire logic       terminal_count,
  input  wire logic       index_pulse_input,
  input  wire logic       id_valid,
  input  wire logic [31:0] id_chrn,
  input  wire logic       id_crc_ok,
  input  wire logic       dam_valid,
  input  wire logic       dam_deleted,
  input  wire logic       byte_slot,
  input  wire logic       field_end,
  input  wire logic       field_crc_ok,
  input  wire logic [7:0] rd_byte,
  output logic            head_load,
  output logic            wr_mark,
  output logic            wr_mark_deleted,
  output logic            wr_byte_valid,
  output logic [7:0]      wr_byte,
  output logic            wr_crc,
  output logic            busy,
  output logic            cmd_done
);
  fstc_pkg::fstc_state_e st_r, st_nxt;
  logic [2:0]  op_r, op_nxt;
  logic        mt_r, mt_nxt, sk_r, sk_nxt, ec_r, ec_nxt;
  logic [7:0]  c_r, c_nxt, h_r, h_nxt, r_r, r_nxt, n_r, n_nxt;
  logic [7:0]  eot_r, eot_nxt, dtl_r, dtl_nxt, spp_r, spp_nxt, hlt_r, hlt_nxt;
  logic [7:0]  hcnt_r, hcnt_nxt, trk_r, trk_nxt, hbuf_r, hbuf_nxt;
  logic [1:0]  idx_r, idx_nxt, ic_r, ic_nxt;
  logic [14:0] cnt_r, cnt_nxt;
  logic [8:0]  scnt_r, scnt_nxt;
  logic        seen_r, seen_nxt, send_r, send_nxt, cms_r, cms_nxt, tc_r, tc_nxt;
  logic        nd_r, nd_nxt, ma_r, ma_nxt, de_r, de_nxt, dd_r, dd_nxt, cm_r, cm_nxt;
  logic        inv_r, inv_nxt, ovr_r, ovr_nxt, unr_r, unr_nxt, hfull_r, hfull_nxt;
  logic        busy_r, busy_nxt, done_r, done_nxt, hld_r, hld_nxt;
  logic        wm_r, wm_nxt, wd_r, wd_nxt, wv_r, wv_nxt, wc_r, wc_nxt;
  logic [7:0]  wb_r, wb_nxt;
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        acc, bwr, brd, hit, rd_op, wr_op;
  logic [14:0] size, lim;
  logic [9:0]  remain;

  // Bus access completes on the edge where pready is seen high
  assign acc   = psel & penable & pready_r;
  assign bwr   = acc & pwrite;
  assign brd   = acc & ~pwrite;
  assign hit   = (paddr == fstc_pkg::OFS_CTRL) | (paddr == fstc_pkg::OFS_ADDR) | (paddr == fstc_pkg::OFS_PARAM) |
                 (paddr == fstc_pkg::OFS_STATUS) | (paddr == fstc_pkg::OFS_DATA);
  assign rd_op = (op_r == fstc_pkg::OP_RDAT) | (op_r == fstc_pkg::OP_RDEL) | (op_r == fstc_pkg::OP_VRFY);
  assign wr_op = (op_r == fstc_pkg::OP_WDAT) | (op_r == fstc_pkg::OP_WDEL);
  // Sector size and transfer limit; short length only applies to size code 0
  assign size  = fstc_pkg::SIZE0_BYTES << n_r[2:0];
  assign lim   = (n_r == 8'h00 && {7'h00, dtl_r} < fstc_pkg::SIZE0_BYTES) ? {7'h00, dtl_r} : size;
  // Formatted sectors left from the start sector, side 1 included under multi-track
  assign remain = {2'h0, spp_r} - {2'h0, r_r} + 10'h001 + ((mt_r && h_r[0] == 1'b0) ? {2'h0, spp_r} : 10'h000);

  // Sequencer next state
  always_comb begin
    logic fin, adv, stop, last;
    fin = 1'b0; adv = 1'b0; stop = 1'b0;
    last = (r_r == eot_r);
    st_nxt = st_r; op_nxt = op_r; mt_nxt = mt_r; sk_nxt = sk_r; ec_nxt = ec_r;
    c_nxt = c_r; h_nxt = h_r; r_nxt = r_r; n_nxt = n_r;
    eot_nxt = eot_r; dtl_nxt = dtl_r; spp_nxt = spp_r; hlt_nxt = hlt_r;
    hcnt_nxt = hcnt_r; trk_nxt = trk_r; hbuf_nxt = hbuf_r; idx_nxt = idx_r; ic_nxt = ic_r;
    cnt_nxt = cnt_r; scnt_nxt = scnt_r; seen_nxt = seen_r; send_nxt = send_r; cms_nxt = cms_r;
    tc_nxt = tc_r; nd_nxt = nd_r; ma_nxt = ma_r; de_nxt = de_r; dd_nxt = dd_r; cm_nxt = cm_r;
    inv_nxt = inv_r; ovr_nxt = ovr_r; unr_nxt = unr_r; hfull_nxt = hfull_r;
    busy_nxt = busy_r; hld_nxt = hld_r; wd_nxt = wd_r; wb_nxt = wb_r;
    done_nxt = 1'b0; wm_nxt = 1'b0; wv_nxt = 1'b0; wc_nxt = 1'b0;
    // Host data register: a bus read pops, a bus write fills
    if (brd && paddr == fstc_pkg::OFS_DATA) hfull_nxt = 1'b0;
    if (bwr && paddr == fstc_pkg::OFS_DATA) begin
      hbuf_nxt = pwdata[7:0];
      hfull_nxt = 1'b1;
    end
    // Host end of transfer is latched; verify has no host transfer so the pin is ignored
    if (busy_r && terminal_count && op_r != fstc_pkg::OP_VRFY) tc_nxt = 1'b1;
    if (!busy_r && bwr) begin
      unique case (paddr)
        fstc_pkg::OFS_ADDR: begin
          c_nxt = pwdata[7:0]; h_nxt = pwdata[15:8]; r_nxt = pwdata[23:16]; n_nxt = pwdata[31:24];
        end
        fstc_pkg::OFS_PARAM: begin
          eot_nxt = pwdata[7:0]; dtl_nxt = pwdata[15:8]; spp_nxt = pwdata[23:16]; hlt_nxt = pwdata[31:24];
        end
        fstc_pkg::OFS_CTRL: begin
          if (pwdata[fstc_pkg::CTL_UNLD]) hld_nxt = 1'b0;
          if (pwdata[fstc_pkg::CTL_START]) begin
            op_nxt = pwdata[fstc_pkg::CTL_OP +: 3]; mt_nxt = pwdata[fstc_pkg::CTL_MT];
            sk_nxt = pwdata[fstc_pkg::CTL_SK]; ec_nxt = pwdata[fstc_pkg::CTL_EC];
            busy_nxt = 1'b1; st_nxt = fstc_pkg::S_HEAD; hcnt_nxt = 8'h00;
            {nd_nxt, ma_nxt, de_nxt, dd_nxt, cm_nxt, inv_nxt, ovr_nxt, unr_nxt, tc_nxt} = 9'h000;
            ic_nxt = fstc_pkg::IC_NORM; idx_nxt = 2'h0; seen_nxt = 1'b0; trk_nxt = 8'h00;
            scnt_nxt = {dtl_r == 8'h00, dtl_r};
          end
        end
        default: ;
      endcase
    end
    unique case (st_r)
      fstc_pkg::S_IDLE: ;
      // Head load wait: none when the head is still loaded, else at most one cycle, as head_load rises on entry whatever hlt_r holds
      fstc_pkg::S_HEAD: begin
        hld_nxt = 1'b1;
        hcnt_nxt = hcnt_r + 8'h01;
        if (hld_r || hcnt_r >= hlt_r) begin
          if (op_r == fstc_pkg::OP_VRFY &&
              (eot_r > spp_r || (ec_r && {1'b0, scnt_r} > remain))) begin
            inv_nxt = 1'b1; ic_nxt = fstc_pkg::IC_ABN; stop = 1'b1;
          end else begin
            st_nxt = (op_r == fstc_pkg::OP_RTRK) ? fstc_pkg::S_IDX : fstc_pkg::S_SRCH;
          end
        end
      end
      fstc_pkg::S_IDX: if (index_pulse_input) st_nxt = fstc_pkg::S_SRCH;
      // ID scan with two-revolution timeout
      fstc_pkg::S_SRCH: begin
        if (index_pulse_input) begin
          idx_nxt = idx_r + 2'h1;
          if (idx_r == 2'h1 && (op_r != fstc_pkg::OP_RTRK || !seen_r)) begin
            ic_nxt = fstc_pkg::IC_ABN; stop = 1'b1;
            if (seen_r) nd_nxt = 1'b1;
            else ma_nxt = 1'b1;
          end
        end else if (id_valid) begin
          seen_nxt = 1'b1;
          cnt_nxt = 15'h0000; cms_nxt = 1'b0;
          send_nxt = (op_r != fstc_pkg::OP_VRFY) && !tc_r;
          if (op_r == fstc_pkg::OP_RTRK) begin
            if (!id_crc_ok) begin de_nxt = 1'b1; dd_nxt = 1'b1; end
            if (id_chrn != {n_r, r_r, h_r, c_r}) nd_nxt = 1'b1;
            st_nxt = fstc_pkg::S_MARK;
          end else if (!id_crc_ok) begin
            ic_nxt = fstc_pkg::IC_ABN; de_nxt = 1'b1; stop = 1'b1;
            if (rd_op) dd_nxt = 1'b1;
          end else if (id_chrn == {n_r, r_r, h_r, c_r}) begin
            idx_nxt = 2'h0;
            if (wr_op) begin
              wm_nxt = 1'b1; wd_nxt = (op_r == fstc_pkg::OP_WDEL);
              st_nxt = fstc_pkg::S_XFER;
            end else st_nxt = fstc_pkg::S_MARK;
          end
        end
      end
      // Data mark type decides read, skip or last sector
      fstc_pkg::S_MARK: if (dam_valid) begin
        st_nxt = fstc_pkg::S_XFER;
        if (op_r != fstc_pkg::OP_RTRK && dam_deleted != (op_r == fstc_pkg::OP_RDEL)) begin
          cm_nxt = 1'b1;
          if (sk_r) begin
            fin = 1'b1; adv = 1'b1;
          end else cms_nxt = 1'b1;
        end
      end
      fstc_pkg::S_XFER: begin
        if (wr_op && byte_slot) begin
          cnt_nxt = cnt_r + 15'h0001;
          wv_nxt = 1'b1; wb_nxt = 8'h00;
          if (cnt_r < lim && !tc_r) begin
            if (hfull_r) begin
              // A host byte landing in this same cycle stays pending
              wb_nxt = hbuf_r; hfull_nxt = bwr && paddr == fstc_pkg::OFS_DATA;
            end else begin
              unr_nxt = 1'b1; tc_nxt = 1'b1;
            end
          end
          if (cnt_r == size - 15'h0001) begin
            wc_nxt = 1'b1; fin = 1'b1; adv = 1'b1;
          end
        end else if (!wr_op && byte_slot) begin
          cnt_nxt = cnt_r + 15'h0001;
          if (send_r && !tc_r && cnt_r < lim) begin
            if (hfull_nxt) begin
              ovr_nxt = 1'b1; tc_nxt = 1'b1;
            end else begin
              hbuf_nxt = rd_byte; hfull_nxt = 1'b1;
            end
          end
        end else if (!wr_op && field_end) begin
          fin = 1'b1; adv = !cms_r;
          if (!field_crc_ok) begin
            de_nxt = 1'b1;
            if (op_r != fstc_pkg::OP_RTRK) begin ic_nxt = fstc_pkg::IC_ABN; stop = 1'b1; adv = 1'b0; end
          end
          if (cms_r) stop = 1'b1;
        end
      end
      default: stop = 1'b1;
    endcase
    // Sector completion: address update per result table and end conditions
    if (fin) begin
      st_nxt = fstc_pkg::S_SRCH; idx_nxt = 2'h0;
      if (op_r == fstc_pkg::OP_RTRK) begin
        trk_nxt = trk_r + 8'h01;
        if (trk_r + 8'h01 == eot_r) stop = 1'b1;
        adv = 1'b0;
      end
      if (op_r == fstc_pkg::OP_VRFY && ec_r) begin
        scnt_nxt = scnt_r - 9'h001;
        if (scnt_r == 9'h001) stop = 1'b1;
      end
      if (tc_r || tc_nxt) stop = 1'b1;
      if (adv) begin
        if (!last) r_nxt = r_r + 8'h01;
        else begin
          r_nxt = fstc_pkg::SEC_FIRST;
          if (!mt_r) begin
            c_nxt = c_r + 8'h01; stop = 1'b1;
          end else begin
            h_nxt = {h_r[7:1], ~h_r[0]};
            if (h_r[0]) begin c_nxt = c_r + 8'h01; stop = 1'b1; end
          end
        end
      end
    end
    if (stop) begin
      st_nxt = fstc_pkg::S_IDLE; busy_nxt = 1'b0; done_nxt = 1'b1;
    end
  end

  // Sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= fstc_pkg::S_IDLE; op_r <= fstc_pkg::OP_RDAT; mt_r <= 1'b0; sk_r <= 1'b0; ec_r <= 1'b0;
      c_r <= fstc_pkg::PARAM_RST; h_r <= fstc_pkg::PARAM_RST; r_r <= fstc_pkg::PARAM_RST; n_r <= fstc_pkg::PARAM_RST;
      eot_r <= fstc_pkg::PARAM_RST; dtl_r <= fstc_pkg::PARAM_RST; spp_r <= fstc_pkg::PARAM_RST;
      hlt_r <= fstc_pkg::PARAM_RST; hcnt_r <= 8'h00; trk_r <= 8'h00; hbuf_r <= 8'h00;
      idx_r <= 2'h0; ic_r <= fstc_pkg::IC_NORM; cnt_r <= 15'h0000; scnt_r <= 9'h000;
      seen_r <= 1'b0; send_r <= 1'b0; cms_r <= 1'b0; tc_r <= 1'b0;
      nd_r <= 1'b0; ma_r <= 1'b0; de_r <= 1'b0; dd_r <= 1'b0; cm_r <= 1'b0;
      inv_r <= 1'b0; ovr_r <= 1'b0; unr_r <= 1'b0; hfull_r <= 1'b0;
      busy_r <= 1'b0; done_r <= 1'b0; hld_r <= 1'b0;
      wm_r <= 1'b0; wd_r <= 1'b0; wv_r <= 1'b0; wb_r <= 8'h00; wc_r <= 1'b0;
    end else begin
      st_r <= st_nxt; op_r <= op_nxt; mt_r <= mt_nxt; sk_r <= sk_nxt; ec_r <= ec_nxt;
      c_r <= c_nxt; h_r <= h_nxt; r_r <= r_nxt; n_r <= n_nxt;
      eot_r <= eot_nxt; dtl_r <= dtl_nxt; spp_r <= spp_nxt; hlt_r <= hlt_nxt;
      hcnt_r <= hcnt_nxt; trk_r <= trk_nxt; hbuf_r <= hbuf_nxt;
      idx_r <= idx_nxt; ic_r <= ic_nxt; cnt_r <= cnt_nxt; scnt_r <= scnt_nxt;
      seen_r <= seen_nxt; send_r <= send_nxt; cms_r <= cms_nxt; tc_r <= tc_nxt;
      nd_r <= nd_nxt; ma_r <= ma_nxt; de_r <= de_nxt; dd_r <= dd_nxt; cm_r <= cm_nxt;
      inv_r <= inv_nxt; ovr_r <= ovr_nxt; unr_r <= unr_nxt; hfull_r <= hfull_nxt;
      busy_r <= busy_nxt; done_r <= done_nxt; hld_r <= hld_nxt;
      wm_r <= wm_nxt; wd_r <= wd_nxt; wv_r <= wv_nxt; wb_r <= wb_nxt; wc_r <= wc_nxt;
    end
  end

  // APB answer: one wait state so read data comes from a flop
  always_comb begin
    pready_nxt = psel & penable & ~pready_r;
    pslverr_nxt = pready_nxt & ~hit;
    prdata_nxt = 32'h0000_0000;
    if (pready_nxt && !pwrite) begin
      unique case (paddr)
        fstc_pkg::OFS_CTRL:   prdata_nxt = {25'h0, ec_r, sk_r, mt_r, op_r, 1'b0};
        fstc_pkg::OFS_ADDR:   prdata_nxt = {n_r, r_r, h_r, c_r};
        fstc_pkg::OFS_PARAM:  prdata_nxt = {hlt_r, spp_r, dtl_r, eot_r};
        fstc_pkg::OFS_STATUS: prdata_nxt = {20'h0, hfull_r, unr_r, ovr_r, inv_r, cm_r, dd_r, de_r, ma_r, nd_r,
                                            ic_r, busy_r};
        fstc_pkg::OFS_DATA:   prdata_nxt = {24'h0, hbuf_r};
        default:              prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // APB registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0; pslverr_r <= 1'b0; prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= pready_nxt; pslverr_r <= pslverr_nxt; prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign head_load = hld_r;
  assign wr_mark = wm_r;
  assign wr_mark_deleted = wd_r;
  assign wr_byte_valid = wv_r;
  assign wr_byte = wb_r;
  assign wr_crc = wc_r;
  assign busy = busy_r;
  assign cmd_done = done_r;

  // Checks
  sequence s_two_idx_noid;
    st_r == fstc_pkg::S_SRCH && !seen_r && idx_r == 2'h1 && index_pulse_input;
  endsequence
  a_missing_mark_end: assert property (@(posedge pclk) disable iff (!presetn)
    s_two_idx_noid |=> ma_r && ic_r == fstc_pkg::IC_ABN && cmd_done && !busy) else $error("missing mark not ended");
  a_verify_no_host: assert property (@(posedge pclk) disable iff (!presetn)
    busy_r && op_r == fstc_pkg::OP_VRFY && st_r == fstc_pkg::S_XFER |=> !ovr_r && $stable(hfull_r) || $fell(hfull_r))
    else $error("verify moved data to host");
  a_verify_tc_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    busy_r && op_r == fstc_pkg::OP_VRFY && !tc_r |=> !tc_r) else $error("verify took terminal count");
  a_write_pad_zero: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == fstc_pkg::S_XFER && wr_op && byte_slot && tc_r |=> wv_r && wb_r == 8'h00)
    else $error("write not padded with zero");
  a_wdel_mark: assert property (@(posedge pclk) disable iff (!presetn)
    wm_r |-> wd_r == (op_r == fstc_pkg::OP_WDEL)) else $error("wrong data mark type");
  a_id_crc_write: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == fstc_pkg::S_SRCH && wr_op && id_valid && !id_crc_ok && !index_pulse_input
    |=> de_r && ic_r == fstc_pkg::IC_ABN && !busy_r) else $error("write ID CRC error not ended");
  a_track_crc_on: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == fstc_pkg::S_SRCH && op_r == fstc_pkg::OP_RTRK && id_valid && !id_crc_ok && !index_pulse_input
    |=> busy_r && de_r ##0 st_r == fstc_pkg::S_MARK) else $error("read track stopped on CRC");
  a_track_idx_start: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == fstc_pkg::S_IDX && !index_pulse_input |=> st_r == fstc_pkg::S_IDX) else $error("track began without index");
  a_result_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == fstc_pkg::S_XFER && wr_op && !mt_r && byte_slot && cnt_r == size - 15'h0001 && r_r == eot_r
    |=> r_r == fstc_pkg::SEC_FIRST && c_r == $past(c_r) + 8'h01 && !busy_r) else $error("result ID not wrapped");
endmodule // fstc_core
`default_nettype wire

/* File: dv/fstc_drive_model.sv */
// Drive model: rotating track of four 128-byte sectors, 512 cycles each
`default_nettype none
module fstc_drive_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] cyl,
  input  wire logic       hd,
  input  wire logic       no_id,
  input  wire logic       bad_crc,
  output logic            index_pulse_input,
  output logic            id_valid,
  output logic [31:0]     id_chrn,
  output logic            id_crc_ok,
  output logic            dam_valid,
  output logic            dam_deleted,
  output logic            byte_slot,
  output logic            field_end,
  output logic            field_crc_ok,
  output logic [7:0]      rd_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] t_r;
  // Free-running spindle; byte slots every other cycle leave the sequencer slack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) t_r <= 11'h000;
    else t_r <= t_r + 11'h001;
  end
  // Sector 4 has a deleted mark; qualifiers carry junk outside their pulses
  assign index_pulse_input = (t_r == 11'h002);
  assign id_valid = (t_r[8:0] == 9'h008) && !no_id;
  assign id_chrn = id_valid ? {8'h00, 8'(t_r[10:9]) + 8'h01, 7'h00, hd, cyl} : {21'h0, t_r};
  assign id_crc_ok = id_valid ? !bad_crc : t_r[0];
  assign dam_valid = (t_r[8:0] == 9'h01e) && !no_id;
  assign dam_deleted = dam_valid ? (t_r[10:9] == 2'h3) : t_r[1];
  assign byte_slot = (t_r[8:0] >= 9'h028) && (t_r[8:0] < 9'h128) && !t_r[0] && !no_id;
  assign field_end = (t_r[8:0] == 9'h12c) && !no_id;
  assign field_crc_ok = field_end || t_r[2];
  assign rd_byte = t_r[7:0];
endmodule // fstc_drive_model
`default_nettype wire

/* File: dv/tb_fstc_core.sv */
// Self-checking bench: sequencer against the drive model, scoreboarded
`default_nettype none
module tb_fstc_core;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [32:0] v; logic [32:0] m;} fstc_note_s;
  localparam logic [32:0] WM = 33'h1_0000_0000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, terminal_count, hd, no_id, bad_crc, head_load;
  logic index_pulse_input, id_valid, id_crc_ok, dam_valid, dam_deleted, byte_slot, field_end, field_crc_ok;
  logic wr_mark, wr_mark_deleted, wr_byte_valid, wr_crc, busy, cmd_done, mq[$];
  logic [7:0] paddr, cyl, rd_byte, wr_byte, bq[$];
  logic [31:0] pwdata, prdata, id_chrn, seed, exp_a;
  int mismatches, checked, cycles;
  fstc_note_s q[$];
  fstc_core i_fstc_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .terminal_count(terminal_count), .index_pulse_input(index_pulse_input), .id_valid(id_valid),
    .id_chrn(id_chrn), .id_crc_ok(id_crc_ok), .dam_valid(dam_valid), .dam_deleted(dam_deleted),
    .byte_slot(byte_slot), .field_end(field_end), .field_crc_ok(field_crc_ok), .rd_byte(rd_byte),
    .head_load(head_load), .wr_mark(wr_mark), .wr_mark_deleted(wr_mark_deleted), .wr_byte_valid(wr_byte_valid),
    .wr_byte(wr_byte), .wr_crc(wr_crc), .busy(busy), .cmd_done(cmd_done));
  fstc_drive_model i_fstc_drive_model (.pclk(pclk), .presetn(presetn), .cyl(cyl), .hd(hd), .no_id(no_id),
    .bad_crc(bad_crc), .index_pulse_input(index_pulse_input), .id_valid(id_valid), .id_chrn(id_chrn),
    .id_crc_ok(id_crc_ok), .dam_valid(dam_valid), .dam_deleted(dam_deleted), .byte_slot(byte_slot),
    .field_end(field_end), .field_crc_ok(field_crc_ok), .rd_byte(rd_byte));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // One APB transfer; an idle cycle after it keeps psel from toggling twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] ev, input logic [32:0] em);
    q.push_back('{ev, em});
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
  endtask
  // Random cylinder, head, parameters and start; waits for the done pulse
  task automatic cmd(input logic [7:0] r, input logic h, input logic [7:0] sc, input logic [7:0] final_sector_number,
                     input logic [2:0] op, input logic mt, input logic sk, input logic ec);
    seed = lfsr(seed);
    cyl <= seed[7:0];
    hd <= h;
    apb(1'b1, fstc_pkg::OFS_ADDR, {8'h00, r, 7'h00, h, seed[7:0]}, 33'h0, WM);
    apb(1'b1, fstc_pkg::OFS_PARAM, {8'h03, 8'h04, sc, final_sector_number}, 33'h0, WM);
    apb(1'b1, fstc_pkg::OFS_CTRL, {24'h0, 1'b0, ec, sk, mt, op, 1'b1}, 33'h0, WM);
    do @(posedge pclk); while (cmd_done !== 1'b1);
  endtask
  // Scoreboard retiring the oldest note of each kind, plus the run's time limit
  always @(posedge pclk) begin : mon
    fstc_note_s n;
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      final_report();
    end
    if (pready === 1'b1) begin
      n = q.pop_front();
      check({pslverr, prdata} & n.m, n.v & n.m);
    end
    if (wr_mark === 1'b1) check({32'h0, wr_mark_deleted}, mq.size() ? {32'h0, mq.pop_front()} : WM);
    if (wr_byte_valid === 1'b1) check({25'h0, wr_byte}, bq.size() ? {25'h0, bq.pop_front()} : WM);
    if (wr_crc === 1'b1) check(33'(bq.size()), 33'h0);
  end
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Host moves no data during a command, so each read or write ends after its first sector
  initial begin
    {presetn, psel, penable, pwrite, terminal_count, hd, no_id, bad_crc, paddr, cyl, pwdata} = '0;
    seed = 32'hee38bdfb;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h14, 32'h0, WM, 33'h1_ffff_ffff);
    for (int i = 0; i < 4; i++) begin
      cmd(i ? 8'h03 : 8'h02, i[0], 8'hff, 8'h03, fstc_pkg::OP_RDAT, i[1], 1'b0, 1'b0);
      exp_a = {8'h00, i ? 8'h01 : 8'h03, 7'h00, i[0] ^ i[1], cyl + 8'(i[0])};
      rd(fstc_pkg::OFS_ADDR, exp_a, '1);
    end
    check({31'h0, head_load, busy}, 33'h2);
    cmd(8'h01, 1'b0, 8'hff, 8'h04, fstc_pkg::OP_RDEL, 1'b0, 1'b0, 1'b0);
    rd(fstc_pkg::OFS_STATUS, 32'h80, 32'h80);
    rd(fstc_pkg::OFS_ADDR, {16'h0001, 8'h00, cyl}, '1);
    no_id <= 1'b1;
    cmd(8'h01, 1'b0, 8'hff, 8'h04, fstc_pkg::OP_RTRK, 1'b0, 1'b0, 1'b0);
    rd(fstc_pkg::OFS_STATUS, 32'h12, 32'h16);
    no_id <= 1'b0;
    // Pop the stale read byte so writes start from an empty host buffer
    rd(fstc_pkg::OFS_DATA, 32'h28, '1);
    for (int j = 0; j < 2; j++) begin
      mq.push_back(j[0]);
      repeat (fstc_pkg::SIZE0_BYTES) bq.push_back(8'h00);
      cmd(8'h01, 1'b0, 8'hff, j ? 8'h01 : 8'h04, j ? fstc_pkg::OP_WDEL : fstc_pkg::OP_WDAT, 1'b0, 1'b0, 1'b0);
      rd(fstc_pkg::OFS_ADDR, {8'h00, 8'h02 - 8'(j), 8'h00, cyl + 8'(j)}, '1);
      check(33'(bq.size() + mq.size()), 33'h0);
    end
    bad_crc <= 1'b1;
    cmd(8'h01, 1'b0, 8'hff, 8'h04, fstc_pkg::OP_WDAT, 1'b0, 1'b0, 1'b0);
    rd(fstc_pkg::OFS_STATUS, 32'h22, 32'h26);
    bad_crc <= 1'b0;
    terminal_count <= 1'b1;
    cmd(8'h01, 1'b0, 8'h02, 8'h04, fstc_pkg::OP_VRFY, 1'b0, 1'b0, 1'b1);
    rd(fstc_pkg::OFS_STATUS, 32'h0, 32'hb06);
    rd(fstc_pkg::OFS_ADDR, {16'h0003, 8'h00, cyl}, '1);
    cmd(8'h01, 1'b0, 8'hff, 8'h05, fstc_pkg::OP_VRFY, 1'b0, 1'b0, 1'b0);
    rd(fstc_pkg::OFS_STATUS, 32'h102, 32'h106);
    final_report();
  end
endmodule // tb_fstc_core
`default_nettype wire
